// >>> sep_pkg.sv
/*
 * Shared constants for the serial EEPROM slave protocol engine.
 * Assumes a single 250 MHz system clock.
 */
package sep_pkg;
	localparam int CLK_MHZ = 250;
	// ---------------------------------------------
	// control byte layout
	// ---------------------------------------------
	localparam logic [3:0] ARRAY_CODE = 4'hA;
	localparam logic [3:0] PROT_CODE = 4'h6;
	localparam int CODE_LSB = 4;
	localparam int CS_LSB = 1;
	localparam int DIR_BIT = 0;
	localparam logic [2:0] SEL_BANK0_CS = 3'h6;
	localparam logic [2:0] SEL_BANK1_CS = 3'h7;
	localparam logic [2:0] READBACK_CS = 3'h6;
	// ---------------------------------------------
	// geometry
	// ---------------------------------------------
	localparam int PAGE_BYTES = 16;
	localparam int PAGE_AW = 4;
	localparam int BLOCK_COUNT = 4;
	localparam logic BANK_RESET = 1'b0;
	// ---------------------------------------------
	// timing
	// ---------------------------------------------
	localparam int WRITE_TIME_MS = 5;
	localparam int TIMEOUT_MIN_MS = 25;
	localparam int TIMEOUT_MAX_MS = 35;
	localparam int WRITE_CYCLES = WRITE_TIME_MS * CLK_MHZ * 1000;
	localparam int TIMEOUT_CYCLES = (TIMEOUT_MIN_MS + TIMEOUT_MAX_MS) / 2 * CLK_MHZ * 1000;
endpackage : sep_pkg

// >>> sep_sync.sv
/*
 * Two-flop synchroniser for one bit.
 * Assumes the input is asynchronous to clk.
 */
`timescale 1ns/1ps
module sep_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic asyncIn,
	output logic syncOut
);
	logic stage1_q;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stage1_q <= RESET_VAL;
			syncOut <= RESET_VAL;
		end
		else
		begin
			stage1_q <= asyncIn;
			syncOut <= stage1_q;
		end
	end
endmodule : sep_sync

// >>> sep_slave.sv
/*
 * Two-wire slave protocol engine of a serial EEPROM: conditions, acknowledge,
 * timeout, control-byte decode, bank select, page buffer, protected-block refusal.
 * Assumes an external memory array behind the prog* and readData ports.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - sda rising while scl high is stop
// - sample data on scl rise, drive on low
// - keep last sixteen bytes, oldest overwritten
// - page address wraps after sixteen bytes
// - acknowledge accepted control, address, data bytes on ninth clock
// - no acknowledge while programming runs
// - hold sda low through ack high phase
// - master nack ends read, release sda
// - clock-low timeout resets, wait for start
// - upper nibble selects array or protect
// - array commands need chip-select match
// - control lsb one read, zero write
// - bank commands ignore chip-select pins
// - bank bit clears at reset and brownout
// - sequential reads wrap within bank
// - bank zero, bank one, readback codes
// - bank set acks control, not dummies
// - array access uses the selected bank; current-address reads start at ptr_q with its old bank bit
// - readback acks only when bank zero
// - byte write: address, data, program at stop
// - protected write gets nack, no cycle
// - page writes: low four address bits increment only
// - sda falling while scl high is start
// - write cycle completes within five ms
module sep_slave #(
	parameter int WRITE_CYC = sep_pkg::WRITE_CYCLES,
	parameter int TIMEOUT_CYC = sep_pkg::TIMEOUT_CYCLES
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic chipSelectPin0,
	input wire logic chipSelectPin1,
	input wire logic chipSelectPin2,
	input wire logic brownoutResetEvent,
	input wire logic [3:0] blockProtect,
	input wire logic [7:0] readData,
	output logic [8:0] readAddr,
	output logic progStart,
	output logic [8:0] progPageAddr,
	output logic [127:0] progData,
	output logic [15:0] progMask,
	output logic progBusy,
	output logic bankSel
);
	initial
	begin
		if (WRITE_CYC < 1 || TIMEOUT_CYC < 2)
			$error("sep_slave: timing counts too small");
	end

	// ---------------------------------------------
	// pin synchronisers and edge detect
	// ---------------------------------------------
	logic sclS, sdaS, bor, csP0, csP1, csP2;
	sep_sync #(.RESET_VAL(1'b1)) uScl (.clk(clk), .arst_n(arst_n), .asyncIn(sclIn), .syncOut(sclS));
	sep_sync #(.RESET_VAL(1'b1)) uSda (.clk(clk), .arst_n(arst_n), .asyncIn(sdaIn), .syncOut(sdaS));
	sep_sync #(.RESET_VAL(1'b0)) uBor (.clk(clk), .arst_n(arst_n), .asyncIn(brownoutResetEvent), .syncOut(bor));
	sep_sync #(.RESET_VAL(1'b0)) uCs0 (.clk(clk), .arst_n(arst_n), .asyncIn(chipSelectPin0), .syncOut(csP0));
	sep_sync #(.RESET_VAL(1'b0)) uCs1 (.clk(clk), .arst_n(arst_n), .asyncIn(chipSelectPin1), .syncOut(csP1));
	sep_sync #(.RESET_VAL(1'b0)) uCs2 (.clk(clk), .arst_n(arst_n), .asyncIn(chipSelectPin2), .syncOut(csP2));

	logic sclP_q, sdaP_q;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclP_q <= 1'b1;
			sdaP_q <= 1'b1;
		end
		else
		begin
			sclP_q <= sclS;
			sdaP_q <= sdaS;
		end
	end
	logic sclRise, sclFall, startCond, stopCond;
	assign sclRise = sclS && !sclP_q;
	assign sclFall = !sclS && sclP_q;
	assign startCond = sclS && sclP_q && sdaP_q && !sdaS;
	assign stopCond = sclS && sclP_q && !sdaP_q && sdaS;

	// ---------------------------------------------
	// protocol state
	// ---------------------------------------------
	typedef enum logic [2:0] {IDLE, CTRL, ADDR, WDATA, RDATA, DUMMY, IGNORE} sep_state_type;
	sep_state_type state_q, state_d;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic [7:0] shift_q, shift_d;
	logic ackPhase_q, ackPhase_d;
	logic doAck_q, doAck_d;
	logic masterNack_q, masterNack_d;
	logic [8:0] ptr_q, ptr_d;
	logic bank_q, bank_d;
	logic [7:0] buf_q [sep_pkg::PAGE_BYTES];
	logic [7:0] buf_d [sep_pkg::PAGE_BYTES];
	logic [15:0] mask_q, mask_d;
	logic pending_q, pending_d;
	logic refused_q, refused_d;
	logic sdaOut_q, sdaOut_d, sdaOe_q, sdaOe_d;
	logic [31:0] busyCnt_q, busyCnt_d;
	logic [31:0] lowCnt_q, lowCnt_d;
	logic progStart_q, progStart_d;
	logic busy;
	logic timeout;
	logic [2:0] csPins;
	assign busy = busyCnt_q != 32'h0;
	assign timeout = lowCnt_q >= TIMEOUT_CYC;
	assign csPins = {csP2, csP1, csP0};

	// clock-low timer; restarts on every rising scl
	always_comb
	begin
		lowCnt_d = lowCnt_q;
		if (sclS)
			lowCnt_d = 32'h0;
		else if (!timeout)
			lowCnt_d = lowCnt_q + 32'h1;
	end

	// write cycle timer
	always_comb
	begin
		busyCnt_d = busyCnt_q;
		if (progStart_q)
			busyCnt_d = WRITE_CYC;
		else if (busy)
			busyCnt_d = busyCnt_q - 32'h1;
	end

	logic [7:0] rxByte;
	always_comb
	begin
		state_d = state_q;
		bitCnt_d = bitCnt_q;
		shift_d = shift_q;
		ackPhase_d = ackPhase_q;
		doAck_d = doAck_q;
		masterNack_d = masterNack_q;
		ptr_d = ptr_q;
		bank_d = bank_q;
		buf_d = buf_q;
		mask_d = mask_q;
		pending_d = pending_q;
		refused_d = refused_q;
		sdaOut_d = sdaOut_q;
		sdaOe_d = sdaOe_q;
		progStart_d = 1'b0;
		rxByte = {shift_q[6:0], sdaS};
		if (timeout && state_q != IDLE)
		begin
			state_d = IGNORE;
			sdaOe_d = 1'b0;
			pending_d = 1'b0;
		end
		else if (startCond)
		begin
			state_d = CTRL;
			bitCnt_d = 4'h0;
			ackPhase_d = 1'b0;
			sdaOe_d = 1'b0;
			pending_d = 1'b0;
		end
		else if (stopCond)
		begin
			if (state_q == WDATA && pending_q && !refused_q)
				progStart_d = 1'b1;
			state_d = IDLE;
			sdaOe_d = 1'b0;
			pending_d = 1'b0;
		end
		else if (state_q != IDLE && state_q != IGNORE)
		begin
			if (sclRise)
			begin
				if (ackPhase_q)
					masterNack_d = sdaS;
				else
				begin
					shift_d = rxByte;
					bitCnt_d = bitCnt_q + 4'h1;
				end
			end
			if (sclFall)
			begin
				if (!ackPhase_q && bitCnt_q == 4'h8)
				begin
					// byte complete: decide on the ninth clock
					ackPhase_d = 1'b1;
					bitCnt_d = 4'h0;
					doAck_d = 1'b0;
					case (state_q)
						CTRL:
						begin
							if (busy)
								state_d = IGNORE;
							else if (shift_q[7:sep_pkg::CODE_LSB] == sep_pkg::ARRAY_CODE)
							begin
								if (shift_q[3:sep_pkg::CS_LSB] != csPins)
									state_d = IGNORE;
								else if (shift_q[sep_pkg::DIR_BIT])
								begin
									state_d = RDATA;
									doAck_d = 1'b1;
								end
								else
								begin
									state_d = ADDR;
									doAck_d = 1'b1;
								end
							end
							else if (shift_q[7:sep_pkg::CODE_LSB] == sep_pkg::PROT_CODE)
							begin
								// chip-select pins not compared here
								state_d = DUMMY;
								if (!shift_q[0] && shift_q[3:1] == sep_pkg::SEL_BANK0_CS)
								begin
									bank_d = 1'b0;
									doAck_d = 1'b1;
								end
								else if (!shift_q[0] && shift_q[3:1] == sep_pkg::SEL_BANK1_CS)
								begin
									bank_d = 1'b1;
									doAck_d = 1'b1;
								end
								else if (shift_q[0] && shift_q[3:1] == sep_pkg::READBACK_CS)
									doAck_d = !bank_q;
								else
									state_d = IGNORE;
							end
							else
								state_d = IGNORE;
						end
						ADDR:
						begin
							ptr_d = {bank_q, shift_q};
							state_d = WDATA;
							doAck_d = 1'b1;
							refused_d = 1'b0;
							mask_d = 16'h0;
						end
						WDATA:
						begin
							if (blockProtect[ptr_q[8:7]])
							begin
								refused_d = 1'b1;
								state_d = IDLE;
							end
							else
							begin
								buf_d[ptr_q[3:0]] = shift_q;
								mask_d[ptr_q[3:0]] = 1'b1;
								ptr_d = {ptr_q[8:4], ptr_q[3:0] + 4'h1};
								pending_d = 1'b1;
								doAck_d = 1'b1;
							end
						end
						default:
							doAck_d = 1'b0;
					endcase
					// after a read byte the ack slot belongs to the master
					sdaOe_d = (state_q == RDATA) ? 1'b0 : doAck_d;
					sdaOut_d = 1'b0;
				end
				else if (ackPhase_q)
				begin
					// ack bit ended; start next byte
					ackPhase_d = 1'b0;
					sdaOe_d = 1'b0;
					if (state_q == RDATA)
					begin
						if (masterNack_q)
							state_d = IDLE;
						else
						begin
							shift_d = readData;
							sdaOe_d = !readData[7];
							ptr_d = {bank_q, ptr_q[7:0] + 8'h1};
						end
					end
				end
				else if (state_q == RDATA)
				begin
					// the shifter moves left on every rise, so the next bit is always on top
					sdaOe_d = !shift_q[7];
					sdaOut_d = 1'b0;
				end
			end
		end
		// brownout wins over a bank command decoded in the same cycle
		if (bor)
			bank_d = sep_pkg::BANK_RESET;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= IDLE;
			bitCnt_q <= 4'h0;
			shift_q <= 8'h00;
			ackPhase_q <= 1'b0;
			doAck_q <= 1'b0;
			masterNack_q <= 1'b0;
			ptr_q <= 9'h000;
			bank_q <= sep_pkg::BANK_RESET;
			for (int i = 0; i < sep_pkg::PAGE_BYTES; i++)
				buf_q[i] <= 8'h00;
			mask_q <= 16'h0000;
			pending_q <= 1'b0;
			refused_q <= 1'b0;
			sdaOut_q <= 1'b0;
			sdaOe_q <= 1'b0;
			busyCnt_q <= 32'h0;
			lowCnt_q <= 32'h0;
			progStart_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			bitCnt_q <= bitCnt_d;
			shift_q <= shift_d;
			ackPhase_q <= ackPhase_d;
			doAck_q <= doAck_d;
			masterNack_q <= masterNack_d;
			ptr_q <= ptr_d;
			bank_q <= bank_d;
			buf_q <= buf_d;
			mask_q <= mask_d;
			pending_q <= pending_d;
			refused_q <= refused_d;
			sdaOut_q <= sdaOut_d;
			sdaOe_q <= sdaOe_d;
			busyCnt_q <= busyCnt_d;
			lowCnt_q <= lowCnt_d;
			progStart_q <= progStart_d;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	// the whole page is handed over; the mask only tells which bytes are new,
	// unmasked bytes are refreshed from the array by the programmer
	logic [127:0] flat;
	genvar g;
	generate
		for (g = 0; g < sep_pkg::PAGE_BYTES; g++)
		begin : gFlat
			assign flat[g*8 +: 8] = buf_q[g];
		end
	endgenerate
	logic [8:0] readAddr_q;
	logic [8:0] pageAddr_q;
	logic [127:0] progData_q;
	logic [15:0] progMask_q;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			readAddr_q <= 9'h000;
			pageAddr_q <= 9'h000;
			progData_q <= 128'h0;
			progMask_q <= 16'h0000;
		end
		else
		begin
			readAddr_q <= ptr_q;
			if (progStart_d)
			begin
				pageAddr_q <= {ptr_q[8:4], 4'h0};
				progData_q <= flat;
				progMask_q <= mask_q;
			end
		end
	end
	assign readAddr = readAddr_q;
	assign progPageAddr = pageAddr_q;
	assign progData = progData_q;
	assign progMask = progMask_q;
	assign progStart = progStart_q;
	assign sdaOut = sdaOut_q;
	assign sdaOe = sdaOe_q;
	assign bankSel = bank_q;
	logic busy_q;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			busy_q <= 1'b0;
		else
			busy_q <= busy || progStart_q;
	end
	assign progBusy = busy_q;

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	a_busy_no_ack: assert property (@(posedge clk) disable iff (!arst_n)
		(busy && $rose(ackPhase_q) && $past(state_q) == CTRL) |-> !sdaOe_q)
		else $error("ack driven while programming");
	a_stop_releases: assert property (@(posedge clk) disable iff (!arst_n)
		stopCond |=> !sdaOe_q)
		else $error("sda held after stop");
	a_prog_len: assert property (@(posedge clk) disable iff (!arst_n)
		progStart_q |=> busy [*8])
		else $error("write cycle ended early");
	a_bank_bor: assert property (@(posedge clk) disable iff (!arst_n)
		bor |=> !bank_q)
		else $error("bank not cleared by brownout");
	a_timeout_idle: assert property (@(posedge clk) disable iff (!arst_n)
		(timeout && state_q != IDLE && !startCond) |=> (state_q == IGNORE && !sdaOe_q))
		else $error("timeout did not reset interface");
	a_ptr_page: assert property (@(posedge clk) disable iff (!arst_n)
		(state_q == WDATA && $past(state_q) == WDATA && $changed(ptr_q)) |-> ptr_q[8:4] == $past(ptr_q[8:4]))
		else $error("page pointer left page");
	a_timer_restart: assert property (@(posedge clk) disable iff (!arst_n)
		sclS |=> lowCnt_q == 32'h0)
		else $error("low timer not restarted");
	a_prot_no_prog: assert property (@(posedge clk) disable iff (!arst_n)
		(refused_q && stopCond) |=> !progStart_q)
		else $error("protected write programmed");
endmodule : sep_slave

// >>> sep_master_model.sv
/*
 * Behavioural two-wire bus master: drives the serial clock, pulls the data line.
 * Assumes a pull-up resolves the data line outside this model.
 */
`timescale 1ns/1ps
module sep_master_model #(
	parameter time HALF = 16ns
) (
	output logic scl,
	output logic sdaOe,
	input wire logic sdaLine
);
	initial
	begin
		scl = 1'b1;
		sdaOe = 1'b0;
	end
	// -----------------------------
	// bus conditions
	// -----------------------------
	task automatic start_cond;
		#2 sdaOe = 1'b0;
		#HALF scl = 1'b1;
		#HALF sdaOe = 1'b1;
		#HALF scl = 1'b0;
	endtask : start_cond
	task automatic stop_cond;
		#2 sdaOe = 1'b1;
		#HALF scl = 1'b1;
		#HALF sdaOe = 1'b0;
		#(2 * HALF);
	endtask : stop_cond
	// -----------------------------
	// one byte plus acknowledge slot
	// -----------------------------
	// inside a byte the clock stays low for only HALF, so the slave timeout stays quiet
	task automatic byte_io(input logic [7:0] tx, input logic mAck, output logic ack, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			#2 sdaOe = ~tx[i];
			#(HALF - 2) scl = 1'b1;
			#HALF rx[i] = sdaLine;
			scl = 1'b0;
		end
		#2 sdaOe = mAck;
		#(HALF - 2) scl = 1'b1;
		#HALF ack = ~sdaLine;
		scl = 1'b0;
	endtask : byte_io
endmodule : sep_master_model

// >>> testbench.sv
/*
 * Self-checking bench for the serial EEPROM slave engine.
 * Assumes the master model above and a pulled-up data line.
 */
`timescale 1ns/1ps
module testbench;
	localparam int WRCYC = 300;
	localparam int TOCYC = 2000;
	logic clk, arst_n, scl, mOe, bor, sdaOut, sdaOe, progStart, progBusy, bankSel, ack;
	logic [2:0] csPins;
	logic [3:0] blockProtect;
	logic [8:0] readAddr, progPageAddr, capPage;
	logic [127:0] progData, capData, expData;
	logic [15:0] progMask, capMask;
	logic [7:0] rx;
	wire logic sdaLine;
	wire logic [7:0] readData;
	int bad_count, num_checks, progCount, cycles;
	// released line floats high through the pull-up
	assign sdaLine = ~mOe & (~sdaOe | sdaOut);
	assign readData = readAddr[7:0] ^ 8'hC3;
	sep_slave #(.WRITE_CYC(WRCYC), .TIMEOUT_CYC(TOCYC)) sep_slave_i (.clk(clk), .arst_n(arst_n),
		.sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectPin0(csPins[0]),
		.chipSelectPin1(csPins[1]), .chipSelectPin2(csPins[2]), .brownoutResetEvent(bor),
		.blockProtect(blockProtect), .readData(readData), .readAddr(readAddr), .progStart(progStart),
		.progPageAddr(progPageAddr), .progData(progData), .progMask(progMask), .progBusy(progBusy),
		.bankSel(bankSel));
	sep_master_model sep_master_model_i (.scl(scl), .sdaOe(mOe), .sdaLine(sdaLine));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// -----------------------------
	// write-cycle capture and hang guard
	// -----------------------------
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (progStart === 1'b1)
		begin
			progCount <= progCount + 1;
			capPage <= progPageAddr;
			capData <= progData;
			capMask <= progMask;
		end
		if (cycles == 30000)
		begin
			bad_count++;
			close_out();
		end
	end
	// -----------------------------
	// tasks
	// -----------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	task automatic chk_val(input string what, input logic [127:0] exp, input logic [127:0] got);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk_val
	task automatic send(input logic [7:0] b, input logic expAck, input string what);
		sep_master_model_i.byte_io(b, 1'b0, ack, rx);
		chk_val(what, 128'(expAck), 128'(ack));
	endtask : send
	task automatic bank_set(input logic [7:0] code);
		sep_master_model_i.start_cond();
		send(code, 1'b1, "bank ctrl");
		send(8'h00, 1'b0, "dummy 1");
		send(8'h00, 1'b0, "dummy 2");
		sep_master_model_i.stop_cond();
		chk_val("bankSel", 128'(code[1]), 128'(bankSel));
	endtask : bank_set
	task automatic wait_idle;
		int n;
		n = 0;
		while (progBusy !== 1'b0 && n < WRCYC + 100)
		begin
			@(posedge clk);
			n++;
		end
		chk_val("progBusy", 128'h0, 128'(progBusy));
	endtask : wait_idle
	// -----------------------------
	// main sequence
	// -----------------------------
	initial
	begin
		arst_n = 1'b0;
		bor = 1'b0;
		csPins = 3'h5;
		blockProtect = 4'h0;
		{bad_count, num_checks, progCount, cycles} = '0;
		repeat (8) @(posedge clk);
		#1 arst_n = 1'b1;
		chk_val("bankSel", 128'h0, 128'(bankSel));
		chk_val("sdaOe", 128'h0, 128'(sdaOe));
		repeat (8) @(posedge clk);
		sep_master_model_i.start_cond();
		send(8'hAA, 1'b1, "ctrl");
		send(8'h35, 1'b1, "addr");
		send(8'h5A, 1'b1, "data");
		sep_master_model_i.stop_cond();
		chk_val("progCount", 128'h1, 128'(progCount));
		chk_val("page", 128'h030, 128'(capPage));
		chk_val("mask", 128'h0020, 128'(capMask));
		chk_val("byte", 128'h5A, 128'(capData[47:40]));
		chk_val("busy", 128'h1, 128'(progBusy));
		sep_master_model_i.start_cond();
		send(8'hAA, 1'b0, "ctrl busy");
		sep_master_model_i.stop_cond();
		wait_idle();
		sep_master_model_i.start_cond();
		send(8'hAA, 1'b1, "ctrl after write");
		sep_master_model_i.start_cond();
		send(8'hA2, 1'b0, "ctrl cs");
		sep_master_model_i.stop_cond();
		$display("byte write done");
		bank_set(8'h6E);
		sep_master_model_i.start_cond();
		send(8'h6D, 1'b0, "readback bank1");
		sep_master_model_i.byte_io(8'hFF, 1'b0, ack, rx);
		chk_val("readback dummy", 128'hFF, 128'(rx));
		sep_master_model_i.stop_cond();
		sep_master_model_i.start_cond();
		send(8'hAA, 1'b1, "ctrl");
		send(8'h2E, 1'b1, "addr");
		for (int j = 0; j < 18; j++)
			send(8'h10 + 8'(j), 1'b1, "page data");
		sep_master_model_i.stop_cond();
		expData = '0;
		for (int j = 0; j < 18; j++)
			expData[8 * ((14 + j) % 16) +: 8] = 8'h10 + 8'(j);
		chk_val("page", 128'h120, 128'(capPage));
		chk_val("mask", 128'hFFFF, 128'(capMask));
		chk_val("data", expData, capData);
		wait_idle();
		$display("page write done");
		sep_master_model_i.start_cond();
		send(8'hAA, 1'b1, "ctrl");
		send(8'hFF, 1'b1, "addr");
		sep_master_model_i.start_cond();
		send(8'hAB, 1'b1, "ctrl read");
		sep_master_model_i.byte_io(8'hFF, 1'b1, ack, rx);
		chk_val("rd 1FF", 128'h3C, 128'(rx));
		sep_master_model_i.byte_io(8'hFF, 1'b0, ack, rx);
		chk_val("rd wrap", 128'hC3, 128'(rx));
		sep_master_model_i.stop_cond();
		bank_set(8'h6C);
		$display("read and bank done");
		@(posedge clk);
		#1 blockProtect = 4'h1;
		sep_master_model_i.start_cond();
		send(8'hAA, 1'b1, "ctrl");
		send(8'h10, 1'b1, "addr");
		send(8'h77, 1'b0, "prot data");
		sep_master_model_i.start_cond();
		send(8'hAA, 1'b1, "ctrl at once");
		sep_master_model_i.stop_cond();
		chk_val("progCount", 128'h2, 128'(progCount));
		$display("protect done");
		bank_set(8'h6E);
		@(posedge clk);
		#1 bor = 1'b1;
		repeat (8) @(posedge clk);
		#1 bor = 1'b0;
		chk_val("bankSel", 128'h0, 128'(bankSel));
		sep_master_model_i.start_cond();
		send(8'h6D, 1'b1, "readback bank0");
		sep_master_model_i.byte_io(8'hFF, 1'b0, ack, rx);
		chk_val("readback dummy 0", 128'hFF, 128'(rx));
		sep_master_model_i.stop_cond();
		$display("brownout done");
		sep_master_model_i.start_cond();
		send(8'hAA, 1'b1, "ctrl");
		repeat (TOCYC + 500) @(posedge clk);
		send(8'h20, 1'b0, "after timeout");
		sep_master_model_i.stop_cond();
		sep_master_model_i.start_cond();
		send(8'hAA, 1'b1, "ctrl new start");
		sep_master_model_i.stop_cond();
		$display("timeout done");
		close_out();
	end
endmodule : testbench
